// >>> src/sac_pkg.sv
// Notes on behaviour
// - odd scan starts 400 ns after even scan
// - I/O store waits 780 ns before scanning
// - empty scan idles; next select starts scan
// - foreign box address: check and regenerate
// - fetch returns word as read, bad parity included; nothing written back
// - store takes only marked bytes from bus
// - store parity checked, word kept, check sent
// - test-and-set returns byte, writes all ones
// - element check goes to every compute processor
// - listed faults give one 525 ns pulse
// - power, stop, temperature faults hold element check
// - logout complete removes stopped element check
// - parity errors give storage check to I/O
// - check starts 2.5 us timeout, halt, pulse
// - no logout stop: resume, clear error latches
// - data/address checks go to compute requester
// - address parity error forces regeneration
// - suppress-log-check skips data parity checks
// - key mismatch gives protect check, regenerates
// - no compare on key cycles; fetch needs protect
// - zero key on either side always permits
// - logic check follows element check, protect excluded
package sac_pkg;
    localparam int CLK_NS = 10;
    localparam int ODD_OFS_NS = 400;
    localparam int ODD_OFS_CYC = (ODD_OFS_NS + CLK_NS - 1) / CLK_NS;
    localparam int IO_DLY_NS = 780;
    localparam int IO_DLY_CYC = (IO_DLY_NS + CLK_NS - 1) / CLK_NS;
    localparam int ELC_PULSE_NS = 525;
    localparam int ELC_PULSE_CYC = (ELC_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMO_NS = 2500;
    localparam int TMO_CYC = TMO_NS / CLK_NS;
    localparam int STORE_CYCLE_NS = 800;
    localparam int N_IO = 3;
    localparam int N_CE = 4;
    localparam int N_REQ = N_IO + N_CE;
    localparam int ADDR_W = 24;
    localparam int BYTE_SEL_W = 3;
    localparam logic [7:0] ONES_BYTE = 8'hff;
    localparam logic ONES_PAR = 1'b1;
    localparam logic [7:0] RESET_DPAR = 8'hff;

    typedef enum logic [2:0] {
        OP_FETCH = 3'h0,
        OP_STORE = 3'h1,
        OP_TAS = 3'h2,
        OP_SET_KEY = 3'h3,
        OP_INS_KEY = 3'h4
    } sac_op_type;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_TMO = 3'b010,
        ST_STOP = 3'b100
    } sac_state_type;

    typedef struct packed {
        logic ce;
        sac_op_type op;
        logic supp;
        logic fprot;
        logic [3:0] key;
        logic [7:0] marks;
        logic [ADDR_W-1:0] addr;
        logic [2:0] apar;
        logic [63:0] data;
        logic [7:0] dpar;
    } sac_acc_type;

    typedef struct packed {
        logic [63:0] data;
        logic [7:0] dpar;
    } sac_word_type;

    typedef struct packed {
        logic vld;
        logic [N_REQ-1:0] req;
        logic [ADDR_W-1:0] addr;
    } sac_err_type;
endpackage

// >>> src/sac_checker.sv
`timescale 1ns/1ps
module sac_checker #(
    parameter int WAW = 4,
    parameter int KAW = 2,
    parameter int CYCLE_NS = sac_pkg::STORE_CYCLE_NS,
    parameter int NPF = 7,
    parameter int NSF = 3
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [sac_pkg::N_REQ-1:0] sel_i,
    input wire logic [sac_pkg::N_REQ-1:0] sel_store_i,
    input wire logic [sac_pkg::N_REQ-1:0] sel_odd_i,
    input wire sac_pkg::sac_acc_type acc_i,
    input wire logic [sac_pkg::ADDR_W-4-WAW:0] box_id_i,
    input wire logic [NPF-1:0] fault_pulse_i,
    input wire logic [NSF-1:0] fault_static_i,
    input wire logic logout_stop_i,
    input wire logic logout_complete_i,
    output logic [sac_pkg::N_REQ-1:0] grant_o,
    output logic busy_o,
    output sac_pkg::sac_word_type rd_o,
    output logic [4:0] rd_key_o,
    output logic rd_vld_o,
    output logic [sac_pkg::N_IO-1:0] io_storage_check_o,
    output logic [sac_pkg::N_CE-1:0] ce_data_check_o,
    output logic [sac_pkg::N_CE-1:0] ce_addr_check_o,
    output logic [sac_pkg::N_REQ-1:0] protect_check_o,
    output logic element_check_o,
    output logic logic_check_o,
    output logic se_stopped_o,
    output sac_pkg::sac_err_type err_info_o
);
    import sac_pkg::*;

    localparam int DEPTH = 1 << WAW;
    localparam int KDEPTH = 1 << KAW;
    localparam int CYC_CYC = CYCLE_NS / CLK_NS;
    localparam int CW = $clog2(CYC_CYC);
    localparam logic [CW-1:0] ODD_P = CW'(ODD_OFS_CYC);
    localparam logic [CW-1:0] LAST_P = CW'(CYC_CYC - 1);
    localparam logic [6:0] IO_MAT = 7'(IO_DLY_CYC);
    localparam logic [5:0] ELC_LOAD = 6'(ELC_PULSE_CYC);
    localparam logic [7:0] TMO_LAST = 8'(TMO_CYC - 1);

    sac_state_type st_q, st_d;
    logic [7:0] tmo_q, tmo_d;
    logic [CW-1:0] phase_q, phase_d, cur;
    logic run_q, run_d, ebusy_q, obusy_q;
    logic [6:0] io_cnt_q [N_IO];
    logic [N_IO-1:0] io_mat;
    sac_word_type mem_q [DEPTH];
    logic [4:0] key_q [KDEPTH];
    sac_word_type rdo_q;
    logic [4:0] rkey_q;
    logic rvld_q;
    logic [N_IO-1:0] io_chk_q;
    logic [N_CE-1:0] ce_dchk_q, ce_achk_q;
    logic [N_REQ-1:0] prot_q;
    logic [5:0] elc_cnt_q;
    logic elc_q;
    logic [NPF-1:0] fp_prev_q;
    sac_err_type err_q;

    // waiting room for I/O stores keeps them out of the scan
    generate
        for (genvar i = 0; i < N_IO; i++) begin : g_io
            always_ff @(posedge core_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    io_cnt_q[i] <= '0;
                end else if (!(sel_i[i] && sel_store_i[i])) begin
                    io_cnt_q[i] <= '0;
                end else if (!io_mat[i]) begin
                    io_cnt_q[i] <= io_cnt_q[i] + 7'd1;
                end
            end
            assign io_mat[i] = io_cnt_q[i] == IO_MAT;
        end
    endgenerate

    wire [N_REQ-1:0] io_hold = {{N_CE{1'b0}}, sel_store_i[N_IO-1:0] & ~io_mat};
    wire [N_REQ-1:0] rdy = sel_i & ~io_hold;
    wire [N_REQ-1:0] rdy_e = rdy & ~sel_odd_i;
    wire [N_REQ-1:0] rdy_o = rdy & sel_odd_i;
    // lowest index wins: I/O sits below compute, so it has priority
    wire [N_REQ-1:0] pick_e = rdy_e & (~rdy_e + 7'd1);
    wire [N_REQ-1:0] pick_o = rdy_o & (~rdy_o + 7'd1);
    wire st_run = st_q == ST_RUN;
    wire start = !run_q && st_run && (|rdy);
    wire adv = run_q || start;
    assign cur = run_q ? phase_q : ((|rdy_e) ? '0 : ODD_P);
    wire pt_e = adv && cur == '0;
    wire pt_o = adv && cur == ODD_P;
    wire found_e = pt_e && st_run && (|rdy_e);
    wire found_o = pt_o && st_run && (|rdy_o);
    wire [N_REQ-1:0] win = found_e ? pick_e : (found_o ? pick_o : '0);
    wire gnt = |win;
    assign phase_d = (cur == LAST_P) ? '0 : cur + 1'b1;

    always_comb begin
        run_d = adv;
        if (pt_e && !found_e && !obusy_q) begin
            run_d = 1'b0;
        end
        if (pt_o && !found_o && !ebusy_q) begin
            run_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_q <= 1'b0;
            phase_q <= '0;
            ebusy_q <= 1'b0;
            obusy_q <= 1'b0;
        end else begin
            run_q <= run_d;
            phase_q <= adv ? phase_d : phase_q;
            ebusy_q <= pt_e ? found_e : ebusy_q;
            obusy_q <= pt_o ? found_o : obusy_q;
        end
    end

    // access decode on the granted request
    wire [WAW-1:0] widx = acc_i.addr[BYTE_SEL_W +: WAW];
    wire [KAW-1:0] kidx = acc_i.addr[BYTE_SEL_W+WAW-KAW +: KAW];
    wire box_miss = acc_i.addr[ADDR_W-1:BYTE_SEL_W+WAW] != box_id_i;
    wire is_fetch = acc_i.op == OP_FETCH;
    wire is_store = acc_i.op == OP_STORE;
    wire is_tas = acc_i.op == OP_TAS;
    wire key_cyc = acc_i.op == OP_SET_KEY || acc_i.op == OP_INS_KEY;
    sac_word_type rdw;
    assign rdw = mem_q[widx];
    logic [2:0] apar_bad;
    logic [7:0] rpar_bad, wpar_bad, ipar_bad;
    logic [63:0] mdata;
    logic [7:0] mpar;

    generate
        for (genvar b = 0; b < 3; b++) begin : g_apar
            assign apar_bad[b] = ~^{acc_i.addr[8*b +: 8], acc_i.apar[b]};
        end
        for (genvar g = 0; g < 8; g++) begin : g_byte
            // I/O test-and-set picks its byte by the low address bits
            wire tsel = acc_i.ce ? acc_i.marks[g] : acc_i.addr[2:0] == 3'(g);
            wire take_in = is_store && acc_i.marks[g];
            wire take_one = is_tas && tsel;
            assign mdata[8*g +: 8] = take_in ? acc_i.data[8*g +: 8]
                : (take_one ? ONES_BYTE : rdw.data[8*g +: 8]);
            assign mpar[g] = take_in ? acc_i.dpar[g] : (take_one ? ONES_PAR : rdw.dpar[g]);
            assign rpar_bad[g] = ~^{rdw.data[8*g +: 8], rdw.dpar[g]};
            assign wpar_bad[g] = ~^{mdata[8*g +: 8], mpar[g]};
            assign ipar_bad[g] = take_in && !acc_i.ce && ~^{acc_i.data[8*g +: 8], acc_i.dpar[g]};
        end
    endgenerate

    wire aperr = |apar_bad;
    wire rd_err = (is_fetch || is_tas) && (|rpar_bad);
    wire wr_err = is_store && ((|wpar_bad) || (|ipar_bad));
    wire data_err = !acc_i.supp && (rd_err || wr_err);
    wire [4:0] skey = key_q[kidx];
    // zero keys act as master keys on either side
    wire cmp_need = !key_cyc && (!is_fetch || skey[4])
        && acc_i.key != 4'h0 && skey[3:0] != 4'h0;
    wire prot = cmp_need && acc_i.key != skey[3:0];
    wire regen = box_miss || aperr || prot || key_cyc;
    wire wr_en = gnt && (is_store || is_tas) && !regen;
    wire chk = data_err || aperr || box_miss;
    wire chk_ev = gnt && st_run && chk;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '{data: '0, dpar: RESET_DPAR};
            end
            for (int k = 0; k < KDEPTH; k++) begin
                key_q[k] <= '0;
            end
        end else begin
            if (wr_en) begin
                mem_q[widx] <= '{data: mdata, dpar: mpar}; // bad parity kept
            end
            if (gnt && acc_i.op == OP_SET_KEY && !box_miss && !aperr) begin
                key_q[kidx] <= {acc_i.fprot, acc_i.key};
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdo_q <= '0;
            rkey_q <= '0;
            rvld_q <= 1'b0;
            io_chk_q <= '0;
            ce_dchk_q <= '0;
            ce_achk_q <= '0;
            prot_q <= '0;
        end else begin
            rvld_q <= gnt;
            if (gnt) begin
                rdo_q <= rdw; // original byte returned on test-and-set
                rkey_q <= skey;
            end
            io_chk_q <= (gnt && !acc_i.ce && chk) ? win[N_IO-1:0] : '0;
            ce_dchk_q <= (gnt && acc_i.ce && data_err) ? win[N_REQ-1:N_IO] : '0;
            ce_achk_q <= (gnt && acc_i.ce && (aperr || box_miss))
                ? win[N_REQ-1:N_IO] : '0;
            prot_q <= (gnt && prot) ? win : '0;
        end
    end

    // stop and logout control
    wire clr_err = (st_q == ST_TMO && !logout_stop_i && tmo_q == '0)
        || (st_q == ST_STOP && logout_complete_i);

    always_comb begin
        st_d = st_q;
        tmo_d = tmo_q;
        unique case (st_q)
            ST_RUN: begin
                if (chk_ev) begin
                    st_d = ST_TMO;
                    tmo_d = TMO_LAST;
                end
            end
            ST_TMO: begin
                if (logout_stop_i) begin
                    st_d = ST_STOP;
                end else if (tmo_q == '0) begin
                    st_d = ST_RUN;
                end else begin
                    tmo_d = tmo_q - 8'd1;
                end
            end
            ST_STOP: begin
                if (logout_complete_i) begin
                    st_d = ST_RUN;
                end
            end
            default: begin
                st_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= ST_RUN;
            tmo_q <= '0;
            err_q <= '0;
        end else begin
            st_q <= st_d;
            tmo_q <= tmo_d;
            if (chk_ev) begin
                err_q <= '{vld: 1'b1, req: win, addr: acc_i.addr};
            end else if (clr_err) begin
                err_q <= '0;
            end
        end
    end

    // element check: pulse on transient faults, level on lasting ones
    wire stopped = st_q == ST_STOP;
    wire pulse_ev = chk_ev || (|(fault_pulse_i & ~fp_prev_q));
    wire static_ev = (|fault_static_i) || stopped;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fp_prev_q <= '0;
            elc_cnt_q <= '0;
            elc_q <= 1'b0;
        end else begin
            fp_prev_q <= fault_pulse_i;
            // retrigger restarts rather than stretches into a second pulse
            elc_cnt_q <= pulse_ev ? ELC_LOAD : (elc_cnt_q != '0 ? elc_cnt_q - 6'd1 : '0);
            elc_q <= (elc_cnt_q != '0) || static_ev;
        end
    end

    assign grant_o = win;
    assign busy_o = run_q;
    assign rd_o = rdo_q;
    assign rd_key_o = rkey_q;
    assign rd_vld_o = rvld_q;
    assign io_storage_check_o = io_chk_q;
    assign ce_data_check_o = ce_dchk_q;
    assign ce_addr_check_o = ce_achk_q;
    assign protect_check_o = prot_q;
    assign element_check_o = elc_q; // one line, fanned to all processors
    assign logic_check_o = elc_q; // protect never feeds elc
    assign se_stopped_o = stopped;
    assign err_info_o = err_q;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    odd_stagger_a: assert property (found_e |-> ##40 pt_o)
        else $error("odd scan not 400 ns after even scan");
    io_store_wait_a: assert property (
        (|(win[N_IO-1:0] & sel_store_i[N_IO-1:0] & ~io_mat)) == 1'b0)
        else $error("I/O store granted before its delay");
    idle_start_a: assert property (start |-> gnt ##1 busy_o)
        else $error("select did not start a scan from idle");
    box_check_a: assert property (gnt && box_miss && !acc_i.ce |=> io_storage_check_o != '0)
        else $error("box miss gave no storage check");
    fetch_out_a: assert property (gnt && is_fetch |=> rd_vld_o && rd_o == $past(rdw))
        else $error("fetch word not returned");
    // i/o byte picked from the address alone, not from the merge logic
    tas_ones_a: assert property (gnt && is_tas && !regen && !acc_i.ce |=>
        mem_q[$past(widx)].data[8*$past(acc_i.addr[2:0]) +: 8] == ONES_BYTE
        && rd_o == $past(rdw))
        else $error("test-and-set write or return wrong");
    apar_regen_a: assert property (gnt && aperr |-> !wr_en)
        else $error("address parity error did not regenerate");
    prot_route_a: assert property (gnt && prot |=> protect_check_o == $past(win))
        else $error("protect check not routed to requester");
    elc_pulse_a: assert property ($rose(elc_cnt_q == ELC_LOAD) |=> element_check_o [*8])
        else $error("element check pulse too short");
    timeout_resume_a: assert property (st_q == ST_TMO && tmo_q == '0 && !logout_stop_i
        |=> st_q == ST_RUN && !err_info_o.vld)
        else $error("no resume after timeout");
    stop_hold_a: assert property (stopped && !logout_complete_i
        |=> stopped && element_check_o)
        else $error("stopped element check dropped early");
    halt_scan_a: assert property (!st_run |-> !gnt)
        else $error("cycle awarded during timeout");

    cov_tas_c: cover property (gnt && is_tas);
    cov_tmo_stop_c: cover property (st_q == ST_TMO ##1 st_q == ST_STOP);
    cov_resume_c: cover property (st_q == ST_TMO ##1 st_q == ST_RUN);
    cov_prot_c: cover property (gnt && prot);
endmodule

// >>> testbench/sac_req_model.sv
`timescale 1ns/1ps
module sac_req_model (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [sac_pkg::N_REQ-1:0] grant_i,
    output logic [sac_pkg::N_REQ-1:0] sel_o,
    output logic [sac_pkg::N_REQ-1:0] store_o,
    output logic [sac_pkg::N_REQ-1:0] odd_o,
    output sac_pkg::sac_acc_type acc_o
);
    import sac_pkg::*;
    sac_acc_type req_acc [N_REQ];
    sac_acc_type last_acc = '0;
    int unsigned posts [N_REQ] = '{default: 0};
    int unsigned takes [N_REQ] = '{default: 0};
    logic [N_REQ-1:0] store_q = '0;
    logic [N_REQ-1:0] odd_q = '0;
    assign store_o = store_q;
    assign odd_o = odd_q;
    // select held until its own award, then dropped
    // one writer each: the task counts posts, the clock counts awards
    always_comb begin
        for (int i = 0; i < N_REQ; i++) begin
            sel_o[i] = posts[i] != takes[i];
        end
    end
    always @(posedge core_clk_i) begin
        for (int i = 0; i < N_REQ; i++) begin
            if (rstn_i && grant_i[i]) takes[i] <= takes[i] + 1;
        end
    end
    // no award: bus shows the inverse of the last word, never a stale copy
    always_comb begin
        acc_o = ~last_acc;
        for (int i = 0; i < N_REQ; i++) begin
            if (grant_i[i]) acc_o = req_acc[i];
        end
    end
    always @(posedge core_clk_i) begin
        if (|grant_i) last_acc <= acc_o;
    end
    // address bit 3 picks the odd scan; store ops raise the store select
    task automatic post(input int idx, input sac_acc_type a);
        req_acc[idx] = a;
        store_q[idx] = (a.op == OP_STORE);
        odd_q[idx] = a.addr[3];
        posts[idx] = posts[idx] + 1;
    endtask
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import sac_pkg::*;
    typedef struct {
        int idx;
        sac_acc_type a;
        logic [63:0] mask;
        logic [63:0] exp;
        logic [3:0] flt;
        logic [2:0] ck;
    } sac_row_type;
    localparam logic [23:0] W = 24'h000008;
    localparam logic [23:0] B = 24'h800008;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [N_REQ-1:0] sel, sel_st, sel_odd, grant, prot;
    sac_acc_type acc;
    logic [6:0] fpulse = '0;
    logic [2:0] fstatic = '0;
    logic lstop = 1'b0;
    logic ldone = 1'b0;
    logic busy, rd_vld, element_check_line, lgc, stopped;
    sac_word_type rd;
    logic [4:0] rd_key;
    logic [N_IO-1:0] io_chk;
    logic [N_CE-1:0] ce_dchk, ce_achk;
    sac_err_type err_info;
    int fail_count = 0;
    int compares = 0;
    sac_row_type rows[$];

    always #5 core_clk_i = ~core_clk_i;

    sac_req_model u_req (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .grant_i(grant),
        .sel_o(sel), .store_o(sel_st), .odd_o(sel_odd), .acc_o(acc));
    sac_checker DUT (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .sel_i(sel),
        .sel_store_i(sel_st), .sel_odd_i(sel_odd), .acc_i(acc), .box_id_i(17'h00000),
        .fault_pulse_i(fpulse), .fault_static_i(fstatic), .logout_stop_i(lstop),
        .logout_complete_i(ldone), .grant_o(grant), .busy_o(busy), .rd_o(rd),
        .rd_key_o(rd_key), .rd_vld_o(rd_vld), .io_storage_check_o(io_chk),
        .ce_data_check_o(ce_dchk), .ce_addr_check_o(ce_achk), .protect_check_o(prot),
        .element_check_o(element_check_line), .logic_check_o(lgc), .se_stopped_o(stopped),
        .err_info_o(err_info));

    task automatic test_done();
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0d ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // odd parity per byte
    function automatic logic [7:0] par(input logic [63:0] d);
        for (int g = 0; g < 8; g++) par[g] = ~^d[8*g+:8];
    endfunction

    // flt: bit0 bad data parity byte 0, bit1 bad address parity, bit2 suppress,
    // bit3 read word expected with bad parity on byte 0
    task automatic add(input int idx, input sac_op_type op, input logic [3:0] key,
        input logic fp, input logic [7:0] m, input logic [23:0] ad, input logic [63:0] d,
        input logic [3:0] flt, input logic [63:0] mask, input logic [63:0] exp,
        input logic [2:0] ck);
        sac_row_type r;
        r.idx = idx;
        r.a.ce = idx >= N_IO;
        r.a.op = op;
        r.a.supp = flt[2];
        r.a.fprot = fp;
        r.a.key = key;
        r.a.marks = m;
        r.a.addr = ad;
        r.a.apar = {~^ad[23:16], ~^ad[15:8], ~^ad[7:0] ^ flt[1]};
        r.a.data = d;
        r.a.dpar = par(d) ^ {7'h00, flt[0]};
        r.mask = mask;
        r.exp = exp;
        r.flt = flt;
        r.ck = ck;
        rows.push_back(r);
    endtask

    // wait bound covers the i/o store delay plus a full check timeout
    task automatic do_op(input int idx, input sac_acc_type a, output int n);
        u_req.post(idx, a);
        for (n = 0; n < 500; n++) begin
            #1;
            if (grant[idx] === 1'b1) break;
            @(negedge core_clk_i);
        end
        if (n == 500) begin
            chk(0, 1);
            test_done();
        end
        @(negedge core_clk_i);
    endtask

    task automatic count_elc(input int len, output int c);
        c = 0;
        repeat (len) begin
            if (element_check_line === 1'b1) c++;
            if (lgc !== element_check_line) chk(lgc, element_check_line);
            @(negedge core_clk_i);
        end
    endtask

    initial begin
        int n;
        int c;
        sac_row_type r;
        add(3, OP_STORE, 0, 0, 8'h0f, W, 64'h1111_2222_3333_4444, 0, 0, 0, 0);
        add(3, OP_FETCH, 0, 0, 0, W, 0, 0, '1, 64'h0000_0000_3333_4444, 0);
        add(0, OP_STORE, 0, 0, 8'hf0, W, 64'haaaa_bbbb_cccc_dddd, 0, 0, 0, 0);
        add(4, OP_FETCH, 0, 0, 0, W, 0, 0, '1, 64'haaaa_bbbb_3333_4444, 0);
        add(1, OP_TAS, 0, 0, 0, 24'h00000a, 0, 0, 64'hff_0000, 64'h33_0000, 0);
        add(3, OP_FETCH, 0, 0, 0, W, 0, 0, '1, 64'haaaa_bbbb_33ff_4444, 0);
        add(5, OP_TAS, 0, 0, 8'h80, W, 0, 0, 64'hff00_0000_0000_0000, 64'haa << 56, 0);
        add(6, OP_FETCH, 0, 0, 0, W, 0, 0, '1, 64'hffaa_bbbb_33ff_4444, 0);
        add(3, OP_SET_KEY, 5, 0, 0, W, 0, 0, 0, 0, 0);
        add(3, OP_STORE, 3, 0, 8'hff, W, 0, 0, 0, 0, 1);
        add(3, OP_FETCH, 3, 0, 0, W, 0, 0, '1, 64'hffaa_bbbb_33ff_4444, 0);
        add(3, OP_STORE, 0, 0, 8'h01, W, 0, 0, 0, 0, 0);
        add(4, OP_FETCH, 5, 0, 0, W, 0, 0, '1, 64'hffaa_bbbb_33ff_4400, 0);
        add(3, OP_SET_KEY, 5, 1, 0, W, 0, 0, 0, 0, 0);
        add(3, OP_FETCH, 3, 0, 0, W, 0, 0, 0, 0, 1);
        add(4, OP_INS_KEY, 3, 0, 0, W, 0, 0, 0, 64'h15, 0);
        add(5, OP_FETCH, 5, 0, 0, W, 0, 0, '1, 64'hffaa_bbbb_33ff_4400, 0);
        add(3, OP_SET_KEY, 0, 0, 0, W, 0, 0, 0, 0, 0);
        add(3, OP_FETCH, 0, 0, 0, B, 0, 0, 0, 0, 4);
        add(2, OP_FETCH, 0, 0, 0, B, 0, 0, 0, 0, 4);
        add(1, OP_STORE, 0, 0, 8'hff, W, 0, 2, 0, 0, 4);
        add(6, OP_FETCH, 0, 0, 0, W, 0, 0, '1, 64'hffaa_bbbb_33ff_4400, 0);
        add(3, OP_STORE, 0, 0, 8'h01, W, 64'h77, 1, 0, 0, 2);
        add(3, OP_FETCH, 0, 0, 0, W, 0, 8, '1, 64'hffaa_bbbb_33ff_4477, 2);
        add(4, OP_FETCH, 0, 0, 0, W, 0, 12, '1, 64'hffaa_bbbb_33ff_4477, 0);
        repeat (5) @(negedge core_clk_i);
        rstn_i = 1'b1;
        chk({busy, rd_vld, element_check_line, lgc, stopped, grant, prot, io_chk}, 0);
        foreach (rows[i]) begin
            r = rows[i];
            do_op(r.idx, r.a, n);
            if (r.idx < N_IO && r.a.op == OP_STORE) chk(n >= IO_DLY_CYC, 1);
            chk(rd_vld, 1);
            chk(rd.data & r.mask, r.exp & r.mask);
            if (r.mask == '1) chk(rd.dpar, par(r.exp) ^ {7'h00, r.flt[3]});
            if (r.a.op == OP_INS_KEY) chk(rd_key, r.exp[4:0]);
            chk(prot, r.ck[0] << r.idx);
            chk(io_chk, (r.idx < N_IO && r.ck[2:1] != 0) << r.idx);
            chk(ce_dchk, (r.idx >= N_IO && r.ck[1]) << (r.idx - N_IO));
            chk(ce_achk, (r.idx >= N_IO && r.ck[2]) << (r.idx - N_IO));
            count_elc(60, c);
            chk(c, r.ck[2:1] != 0 ? ELC_PULSE_CYC : 0);
        end
        for (n = 0; n < 300 && busy !== 1'b0; n++) @(negedge core_clk_i);
        chk(busy, 0);
        add(0, OP_FETCH, 0, 0, 0, 24'h000000, 0, 0, 0, 0, 0);
        add(1, OP_FETCH, 0, 0, 0, W, 0, 0, 0, 0, 0);
        u_req.post(0, rows[$-1].a);
        u_req.post(1, rows[$].a);
        #1;
        chk(grant[0], 1);
        for (n = 0; n < 100 && grant[1] !== 1'b1; n++) begin
            @(negedge core_clk_i);
            #1;
        end
        chk(n, ODD_OFS_CYC);
        repeat (3) @(negedge core_clk_i);
        for (int i = 0; i < 3; i++) begin
            fstatic[i] = 1'b1;
            repeat (4) @(negedge core_clk_i);
            count_elc(90, c);
            chk(c, 90);
            fstatic[i] = 1'b0;
            repeat (5) @(negedge core_clk_i);
            chk(element_check_line, 0);
        end
        for (int i = 0; i < 7; i++) begin
            fpulse[i] = 1'b1;
            count_elc(80, c);
            chk(c, ELC_PULSE_CYC);
            fpulse[i] = 1'b0;
        end
        do_op(3, rows[18].a, n);
        lstop = 1'b1;
        repeat (2) @(negedge core_clk_i);
        lstop = 1'b0;
        repeat (300) @(negedge core_clk_i);
        chk({stopped, element_check_line, lgc, err_info.vld}, 4'hf);
        chk(err_info.addr, B);
        ldone = 1'b1;
        @(negedge core_clk_i);
        ldone = 1'b0;
        repeat (5) @(negedge core_clk_i);
        chk({stopped, element_check_line}, 0);
        do_op(2, rows[19].a, n);
        repeat (5) @(negedge core_clk_i);
        chk({err_info.vld, err_info.req}, 8'h84);
        repeat (260) @(negedge core_clk_i);
        chk({err_info.vld, stopped}, 0);
        test_done();
    end
endmodule
